// [gpio_clock_mask_live_insert_tb.sv]
// Self-checking bench for the pin port, mask loader and halt input.
// Assumes the package constants and a shifter model on pins 0 and 2.
`timescale 1ns/100ps
`default_nettype none
module gpio_clock_mask_live_insert_tb;
    import gpio_mask_pkg::*;
    localparam logic [15:0] STRAPS = 16'h1DC7;
    logic        ref_clk, reset, ce, sec_reset_bit, live_insert_mode;
    logic        cfg_rvalid, fwd_halted, cmpl_return_en, sec_rst_n;
    cfg_req_t    cfg_req;
    cmd_en_t     cmd_written, cmd_effective;
    logic [31:0] cfg_rdata, rd_q;
    logic [3:0]  gpio_out, gpio_oe, ext_pins;
    logic [9:0]  clk_out_en;
    wire  logic [3:0] gpio_in;
    wire  logic       msk_in;
    wire  logic       shift_out;
    logic             strap_tied;
    int          fails = 0, comparisons = 0, cycles = 0;

    // Wire level: driver wins where enabled, board level elsewhere
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_pins);

    gpio_mask_top i_gpio_mask_top (.ref_clk(ref_clk), .reset(reset), .ce(ce),
        .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .msk_in(msk_in),
        .sec_reset_bit(sec_reset_bit), .live_insert_mode(live_insert_mode),
        .cmd_written(cmd_written), .cmd_effective(cmd_effective), .fwd_halted(fwd_halted),
        .cmpl_return_en(cmpl_return_en), .clk_out_en(clk_out_en), .sec_rst_n(sec_rst_n));
    slot_presence_shifter i_slot_presence_shifter (.shift_clk(gpio_in[0]),
        .load_n_shift(gpio_in[2]), .strap_bits(STRAPS), .serial_out(shift_out));
    // Board without a shifter ties the serial line high instead
    assign msk_in = strap_tied ? 1'b1 : shift_out;

    // 200 MHz clock
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    // Hang guard, well above the roughly 700 cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write is stored, then reaches the pins one edge later
    task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk) #1 cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(posedge ref_clk) #1 cfg_req.wr = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // Read data stands for one cycle after the taking edge
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk) #1 cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge ref_clk) #1 cfg_req.rd = 1'b0;
        chk("rvalid", 1, cfg_rvalid);
        d = cfg_rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Clock enables expected from a mask value
    function automatic logic [9:0] exp_en(input logic [15:0] m);
        logic [9:0] e;
        for (int i = 0; i < 4; i++) e[i] = !(m[2*i] && m[2*i+1]);
        for (int i = 4; i < 10; i++) e[i] = !m[i+4];
        return e;
    endfunction

    // Main sequence
    initial begin
        reset = 1'b1; ce = 1'b1; sec_reset_bit = 1'b0; live_insert_mode = 1'b0;
        cmd_written = 3'b101; cfg_req = '0; ext_pins = 4'h8; strap_tied = 1'b0;
        settle(4);
        reset = 1'b0;
        for (int n = 0; n < 300 && sec_rst_n !== 1'b1; n++) @(posedge ref_clk);
        #1;
        chk("sec_rst_n", 1, sec_rst_n);
        chk("oe done", 0, gpio_oe);
        cfg_rd(ADDR_CLK_MASK, rd_q);
        chk("mask", STRAPS, rd_q);
        chk("clk_out_en", exp_en(STRAPS), clk_out_en);
        cfg_wr(ADDR_PIN_CTRL, 32'h00FF_0007, 4'hF);
        chk("oe set", 4'hF, gpio_oe);
        chk("out set", 4'h7, gpio_out);
        cfg_rd(ADDR_PIN_CTRL, rd_q);
        chk("ctrl", 32'h000F_0007, rd_q);
        cfg_wr(ADDR_PIN_CTRL, 32'h0A00_0100, 4'hF);
        chk("oe clear", 4'h5, gpio_oe);
        chk("out clear", 4'h4, gpio_out);
        cfg_wr(ADDR_PIN_CTRL, 32'h0, 4'hF);
        chk("oe zero", 4'h5, gpio_oe);
        chk("out zero", 4'h4, gpio_out);
        cfg_rd(ADDR_PIN_INPUT, rd_q);
        chk("pins", 32'h0000_000C, rd_q);
        live_insert_mode = 1'b1;
        settle(6);
        chk("halt", 1, fwd_halted);
        chk("cmd halted", 0, cmd_effective);
        chk("cmpl halted", 0, cmpl_return_en);
        cmd_written = 3'b110;
        cfg_rd(ADDR_PIN_CTRL, rd_q);
        chk("ctrl halted", 32'h0005_0006, rd_q);
        ext_pins = 4'h0;
        settle(6);
        chk("cmd back", 3'b110, cmd_effective);
        chk("cmpl back", 1, cmpl_return_en);
        ext_pins = 4'h8;
        cfg_wr(ADDR_PIN_CTRL, 32'h0008_0008, 4'hF);
        settle(4);
        chk("halt driven", 0, fwd_halted);
        cfg_wr(ADDR_CLK_MASK, 32'h0000_3F0F, 4'h3);
        cfg_rd(ADDR_CLK_MASK, rd_q);
        chk("mask wr", 32'h0000_3F0F, rd_q);
        chk("clk_out_en wr", exp_en(16'h3F0F), clk_out_en);
        cfg_rd(8'h0C, rd_q);
        chk("unmapped", 0, rd_q);
        sec_reset_bit = 1'b1;
        reset = 1'b1;
        #1;
        chk("oe reset", 0, gpio_oe);
        chk("out reset", 0, gpio_out);
        settle(2);
        reset = 1'b0;
        settle(250);
        chk("held", 0, sec_rst_n);
        sec_reset_bit = 1'b0;
        settle(3);
        chk("freed", 1, sec_rst_n);
        strap_tied = 1'b1;
        reset = 1'b1;
        settle(2);
        reset = 1'b0;
        settle(200);
        cfg_rd(ADDR_CLK_MASK, rd_q);
        chk("mask tied", 32'h0000_FFFF, rd_q);
        chk("clk_out_en tied", 10'h000, clk_out_en);
        complete_run();
    end
endmodule // gpio_clock_mask_live_insert_tb
`default_nettype wire

// [gpio_mask_checker.sv]
// Concurrent checks on the ports of the pin and clock-mask block.
// Assumes one ref_clk domain and a bench that keeps ce high.
`timescale 1ns/100ps
`default_nettype none
module gpio_mask_checker
    import gpio_mask_pkg::*;
(
    // Clocking
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  ce,
    // Configuration access
    input wire gpio_mask_pkg::cfg_req_t cfg_req,
    input wire logic [31:0]           cfg_rdata,
    input wire logic                  cfg_rvalid,
    // Pins and serial input
    input wire logic [3:0]            gpio_in,
    input wire logic [3:0]            gpio_out,
    input wire logic [3:0]            gpio_oe,
    input wire logic                  msk_in,
    // Bridge control and results
    input wire logic                  sec_reset_bit,
    input wire logic                  live_insert_mode,
    input wire gpio_mask_pkg::cmd_en_t cmd_written,
    input wire gpio_mask_pkg::cmd_en_t cmd_effective,
    input wire logic                  fwd_halted,
    input wire logic                  cmpl_return_en,
    input wire logic [9:0]            clk_out_en,
    input wire logic                  sec_rst_n
);
    logic [7:0] rel_cnt_q;

    // Cycles since release; saturates so a held-off release never wraps
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) rel_cnt_q <= 8'h00;
        else if (rel_cnt_q != 8'hFF) rel_cnt_q <= rel_cnt_q + 8'h01;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_read_answer: assert property (cfg_req.rd |=> cfg_rvalid)
        else $error("read not answered next cycle");
    a_load_entry: assert property ($fell(reset) |-> ##[1:3] gpio_oe == SHIFT_DRIVE && !gpio_out[2])
        else $error("loader did not take pins 0 and 2");
    a_load_period: assert property ($rose(gpio_oe[2]) && !sec_rst_n |-> !gpio_out[2] [*8] ##1 gpio_out[2])
        else $error("load control not low for one shift period");
    a_clock_high: assert property ($rose(gpio_out[0]) && !sec_rst_n |-> gpio_out[0] [*4] ##1 !(gpio_out[0] && gpio_oe[0]))
        else $error("shift clock high time wrong");
    a_release_early: assert property ($rose(sec_rst_n) && rel_cnt_q != 8'hFF |-> rel_cnt_q >= 8'hB4)
        else $error("secondary reset released before mask collected");
    a_release_due: assert property (rel_cnt_q == 8'hD2 && !sec_reset_bit |-> sec_rst_n)
        else $error("secondary reset still held after loading");
    a_release_gate: assert property ($rose(sec_rst_n) |-> !$past(sec_reset_bit) && gpio_oe == 4'h0)
        else $error("release with reset bit set or pins driven");
    a_halt_masks: assert property (fwd_halted |-> cmd_effective == 3'h0 && !cmpl_return_en && !gpio_oe[3])
        else $error("halt did not mask enables");
    a_cmd_restore: assert property (!fwd_halted && !$past(reset) |-> cmd_effective == $past(cmd_written) && cmpl_return_en)
        else $error("enables not restored to written values");

    // Main scenarios reached
    c_halted: cover property (fwd_halted);
    c_released: cover property ($rose(sec_rst_n));
    c_read_data: cover property (cfg_rvalid && cfg_rdata != 32'h0);
endmodule // gpio_mask_checker

bind gpio_mask_top gpio_mask_checker i_gpio_mask_checker (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .msk_in(msk_in), .sec_reset_bit(sec_reset_bit), .live_insert_mode(live_insert_mode),
    .cmd_written(cmd_written), .cmd_effective(cmd_effective), .fwd_halted(fwd_halted),
    .cmpl_return_en(cmpl_return_en), .clk_out_en(clk_out_en), .sec_rst_n(sec_rst_n)
);
`default_nettype wire

// [gpio_mask_pkg.sv]
// Package for the general-purpose pin and clock-mask block.
// Holds register indices, field layout, reset values, timing counts and carriers.
// Assumes a 200 MHz reference clock.
package gpio_mask_pkg;

    // Pin and field sizes
    localparam int PIN_COUNT   = 4;
    localparam int FIELD_WIDTH = 8;
    localparam int MASK_WIDTH  = 16;
    localparam int CLK_OUTS    = 10;

    // Configuration word addresses (byte addresses)
    localparam logic [7:0] ADDR_PIN_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_PIN_INPUT = 8'h04;
    localparam logic [7:0] ADDR_CLK_MASK  = 8'h08;

    // Byte lanes within the pin control word
    localparam int LANE_VALUE_SET   = 0;
    localparam int LANE_VALUE_CLEAR = 1;
    localparam int LANE_DRIVE_SET   = 2;
    localparam int LANE_DRIVE_CLEAR = 3;

    // Reset values
    localparam logic [PIN_COUNT-1:0]  RESET_VALUE = 4'h0;
    localparam logic [PIN_COUNT-1:0]  RESET_DRIVE = 4'h0;
    localparam logic [MASK_WIDTH-1:0] RESET_MASK  = 16'h0000;

    // Mask layout
    localparam int PAIR_SLOTS   = 4;
    localparam int SINGLE_FIRST = 8;
    localparam int SELF_CLK_BIT = 13;

    // Pin roles in and after the shift phase
    localparam int PIN_SHIFT_CLK  = 0;
    localparam int PIN_LOAD_SHIFT = 2;
    localparam int PIN_HALT       = 3;
    localparam logic [PIN_COUNT-1:0] SHIFT_DRIVE = 4'h5;

    // Timing
    localparam int REF_CLK_KHZ    = 200000;
    localparam int SHIFT_MAX_KHZ  = 33000;
    localparam int SHIFT_HALF     = (REF_CLK_KHZ + 2*SHIFT_MAX_KHZ - 1) / (2*SHIFT_MAX_KHZ);
    localparam int SHIFT_PERIOD   = 2 * SHIFT_HALF;
    localparam int LOAD_PERIODS   = 1;
    localparam int TOTAL_PERIODS  = 23;
    localparam int LAST_SHIFT     = LOAD_PERIODS + MASK_WIDTH - 1;

    // Sequencer states, Gray along the path
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'h0,
        SEQ_LOAD   = 3'h1,
        SEQ_SHIFT  = 3'h3,
        SEQ_SETTLE = 3'h2,
        SEQ_DONE   = 3'h6
    } seq_state_t;

    // Configuration access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    // Transaction forwarding enables
    typedef struct packed {
        logic io;
        logic mem;
        logic master;
    } cmd_en_t;

endpackage

// [gpio_mask_top.sv]
// Four-pin general-purpose port with serial clock-mask loader and halt input.
// Assumes configuration accesses arrive on ref_clk; pins and msk_in are async.
// What this block does
// - Drive-enable set bit turns pin driver on
// - Drive-enable clear bit tristates pin driver
// - Zero bits in set/clear fields change nothing
// - All pins input only after reset
// - Eight-bit fields, low four bits used
// - Input field reads live pin levels always
// - Value set bit stores high output
// - Value clear bit stores low output
// - Output value resets zero, driven when enabled
// - After reset release, start collecting 16-bit mask
// - Hold secondary reset 23 shift periods
// - Pin 0 shift clock at most 33 MHz
// - Pin 2 low one period, then high
// - Mask arrives MSB first, assembled so
// - Pair bits mask outputs 0-3 only both-one
// - Bits 8-12 disable outputs 4-8 singly
// - Bit 13 gates output 9; 14-15 reserved
// - After shift: tristate, ignore input, conditional release
// - Halt input masks io, mem, master enables
// - Command bits unchanged; enables restore when low
// - Halted: drain queued, withhold delayed completions
`timescale 1ns/100ps
`default_nettype none
module gpio_mask_top
    import gpio_mask_pkg::*;
(
    // Clocking and reset
    input  wire  logic                               ref_clk,
    input  wire  logic                               reset,
    input  wire  logic                               ce,
    // Configuration access
    input  wire  gpio_mask_pkg::cfg_req_t            cfg_req,
    output var   logic [31:0]                        cfg_rdata,
    output var   logic                               cfg_rvalid,
    // General-purpose pins
    input  wire  logic [gpio_mask_pkg::PIN_COUNT-1:0] gpio_in,
    output var   logic [gpio_mask_pkg::PIN_COUNT-1:0] gpio_out,
    output var   logic [gpio_mask_pkg::PIN_COUNT-1:0] gpio_oe,
    // Serial mask input
    input  wire  logic                               msk_in,
    // Bridge control inputs
    input  wire  logic                               sec_reset_bit,
    input  wire  logic                               live_insert_mode,
    input  wire  gpio_mask_pkg::cmd_en_t             cmd_written,
    // Results
    output var   gpio_mask_pkg::cmd_en_t             cmd_effective,
    output var   logic                               fwd_halted,
    output var   logic                               cmpl_return_en,
    output var   logic [gpio_mask_pkg::CLK_OUTS-1:0] clk_out_en,
    output var   logic                               sec_rst_n
);
    import gpio_mask_pkg::*;

    // Decode of the mask into clock-output enables
    function automatic logic [CLK_OUTS-1:0] mask_to_enables(input logic [MASK_WIDTH-1:0] m);
        logic [CLK_OUTS-1:0] en;
        en = '0;
        for (int i = 0; i < PAIR_SLOTS; i++) begin
            en[i] = ~(m[2*i] & m[2*i+1]);
        end
        for (int i = PAIR_SLOTS; i < CLK_OUTS - 1; i++) begin
            en[i] = ~m[SINGLE_FIRST + i - PAIR_SLOTS];
        end
        en[CLK_OUTS-1] = ~m[SELF_CLK_BIT];
        return en;
    endfunction

    // Lane write strobe helper
    function automatic logic [PIN_COUNT-1:0] lane_bits(input cfg_req_t r, input int lane);
        lane_bits = r.be[lane] ? r.wdata[lane*FIELD_WIDTH +: PIN_COUNT] : '0;
    endfunction

    // Synchronised pins and serial input
    logic [PIN_COUNT-1:0] pin_sync;
    logic                 msk_sync;

    sync_stage #(.WIDTH(PIN_COUNT)) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .ce       (ce),
        .async_in (gpio_in),
        .sync_out (pin_sync)
    );

    sync_stage #(.WIDTH(1)) u_msk_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .ce       (ce),
        .async_in (msk_in),
        .sync_out (msk_sync)
    );

    // State
    seq_state_t            state_q;
    logic [4:0]            period_q;
    logic [2:0]            phase_q;
    logic [PIN_COUNT-1:0]  value_q;
    logic [PIN_COUNT-1:0]  drive_q;
    logic [MASK_WIDTH-1:0] mask_q;
    logic                  halt_d;
    logic                  pins_to_regs;
    logic                  sclk_d;
    logic                  sample_now;
    logic                  wr_ctrl;
    logic                  wr_mask;

    localparam logic [2:0] PHASE_LAST  = 3'(SHIFT_PERIOD - 1);
    localparam logic [2:0] PHASE_HIGH  = 3'(SHIFT_HALF);
    localparam logic [2:0] PHASE_SAMPL = 3'(SHIFT_HALF - 1);
    localparam logic [4:0] PER_LOAD    = 5'(LOAD_PERIODS - 1);
    localparam logic [4:0] PER_SHIFT   = 5'(LAST_SHIFT);
    localparam logic [4:0] PER_TOTAL   = 5'(TOTAL_PERIODS - 1);

    assign wr_ctrl      = cfg_req.wr && cfg_req.addr == ADDR_PIN_CTRL;
    assign wr_mask      = cfg_req.wr && cfg_req.addr == ADDR_CLK_MASK;
    assign pins_to_regs = state_q == SEQ_DONE;
    // Shift clock is high in the second half of each period
    assign sclk_d       = phase_q >= PHASE_HIGH;
    // One sample per period, in the last low cycle before the rising edge
    assign sample_now   = state_q == SEQ_SHIFT && phase_q == PHASE_SAMPL;

    // Period and phase counters; the period is 8 cycles, 25 MHz, under the ceiling
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phase_q  <= '0;
            period_q <= '0;
        end else if (ce) begin
            if (state_q == SEQ_IDLE || state_q == SEQ_DONE) begin
                phase_q  <= '0;
                period_q <= '0;
            end else if (phase_q == PHASE_LAST) begin
                phase_q  <= '0;
                period_q <= period_q + 5'h01;
            end else begin
                phase_q  <= phase_q + 3'h1;
            end
        end
    end

    // Sequencer: load, sixteen shifts, then settle until period 23 ends
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= SEQ_IDLE;
        end else if (ce) begin
            unique case (state_q)
                SEQ_IDLE: begin
                    if (!sec_rst_n) begin
                        state_q <= SEQ_LOAD;
                    end
                end
                SEQ_LOAD: begin
                    if (phase_q == PHASE_LAST && period_q == PER_LOAD) begin
                        state_q <= SEQ_SHIFT;
                    end
                end
                SEQ_SHIFT: begin
                    if (phase_q == PHASE_LAST && period_q == PER_SHIFT) begin
                        state_q <= SEQ_SETTLE;
                    end
                end
                SEQ_SETTLE: begin
                    if (phase_q == PHASE_LAST && period_q == PER_TOTAL) begin
                        state_q <= SEQ_DONE;
                    end
                end
                SEQ_DONE: begin
                    state_q <= SEQ_DONE;
                end
                default: begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Clock mask: serial capture during the shift phase, then configuration writes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mask_q <= RESET_MASK;
        end else if (ce) begin
            if (sample_now) begin
                mask_q <= {mask_q[MASK_WIDTH-2:0], msk_sync};
            end else if (wr_mask && pins_to_regs) begin
                // Serial input is ignored from here on; only writes change the mask
                if (cfg_req.be[0]) mask_q[7:0]  <= cfg_req.wdata[7:0];
                if (cfg_req.be[1]) mask_q[15:8] <= cfg_req.wdata[15:8];
            end
        end
    end

    // Output value: set and clear by ones, zeros leave bits alone
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            value_q <= RESET_VALUE;
        end else if (ce && wr_ctrl) begin
            value_q <= (value_q | lane_bits(cfg_req, LANE_VALUE_SET))
                       & ~lane_bits(cfg_req, LANE_VALUE_CLEAR);
        end
    end

    // Drive enable: set and clear by ones, all off after reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drive_q <= RESET_DRIVE;
        end else if (ce && wr_ctrl) begin
            drive_q <= (drive_q | lane_bits(cfg_req, LANE_DRIVE_SET))
                       & ~lane_bits(cfg_req, LANE_DRIVE_CLEAR);
        end
    end

    // Pins: borrowed by the loader, tristated after it, then register-driven
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gpio_out <= '0;
            gpio_oe  <= RESET_DRIVE;
        end else if (ce) begin
            if (state_q == SEQ_LOAD || state_q == SEQ_SHIFT) begin
                gpio_oe                 <= SHIFT_DRIVE;
                gpio_out                <= '0;
                gpio_out[PIN_SHIFT_CLK] <= sclk_d;
                gpio_out[PIN_LOAD_SHIFT] <= state_q == SEQ_SHIFT;
            end else if (pins_to_regs) begin
                gpio_oe  <= drive_q;
                gpio_out <= value_q & drive_q;
            end else begin
                gpio_oe  <= '0;
                gpio_out <= '0;
            end
        end
    end

    // Secondary reset held until the mask is in and the control bit is clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sec_rst_n <= 1'b0;
        end else if (ce) begin
            sec_rst_n <= pins_to_regs && !sec_reset_bit;
        end
    end

    // Clock output enables follow the mask; reserved bits have no effect
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clk_out_en <= '1;
        end else if (ce) begin
            clk_out_en <= mask_to_enables(mask_q);
        end
    end

    // Halt only when the mode is on and pin 3 is not being driven by us
    assign halt_d = live_insert_mode && pins_to_regs
                    && !drive_q[PIN_HALT] && pin_sync[PIN_HALT];

    // Forwarding enables; the written command bits are never altered here
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_effective  <= '0;
            fwd_halted     <= 1'b0;
            cmpl_return_en <= 1'b1;
        end else if (ce) begin
            cmd_effective  <= halt_d ? '0 : cmd_written;
            fwd_halted     <= halt_d;
            // Queued posted writes and requests still drain; completions wait
            cmpl_return_en <= !halt_d;
        end
    end

    // Register reads, one cycle after the request; unmapped words read zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_rdata  <= '0;
            cfg_rvalid <= 1'b0;
        end else if (ce) begin
            cfg_rvalid <= cfg_req.rd;
            cfg_rdata  <= '0;
            if (cfg_req.rd) begin
                unique case (cfg_req.addr)
                    ADDR_PIN_CTRL: begin
                        cfg_rdata[LANE_VALUE_SET*FIELD_WIDTH +: PIN_COUNT] <= value_q;
                        cfg_rdata[LANE_DRIVE_SET*FIELD_WIDTH +: PIN_COUNT] <= drive_q;
                    end
                    ADDR_PIN_INPUT: begin
                        cfg_rdata[PIN_COUNT-1:0] <= pin_sync;
                    end
                    ADDR_CLK_MASK: begin
                        cfg_rdata[MASK_WIDTH-1:0] <= mask_q;
                    end
                    default: begin
                        cfg_rdata <= '0;
                    end
                endcase
            end
        end
    end
endmodule // gpio_mask_top
`default_nettype wire

// [slot_presence_shifter.sv]
// Model of the two cascaded parallel-in serial-out registers on the board.
// Assumes its controls are the resolved pin levels seen on the wires.
`timescale 1ns/100ps
`default_nettype none
module slot_presence_shifter (
    // Control from the pins
    input  wire logic        shift_clk,
    input  wire logic        load_n_shift,
    // Board straps and serial line
    input  wire logic [15:0] strap_bits,
    output var  logic        serial_out
);
    logic [15:0] stage_q;

    // Low control loads the straps, high shifts toward the top; no reset pin
    always_ff @(posedge shift_clk) begin
        if (!load_n_shift) stage_q <= strap_bits;
        else stage_q <= {stage_q[14:0], 1'b0};
    end

    // Top bit leaves first, bottom bit last
    always_comb serial_out = stage_q[15];
endmodule // slot_presence_shifter
`default_nettype wire

// [sync_stage.sv]
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the group need not stay coherent across bits.
`timescale 1ns/100ps
`default_nettype none
module sync_stage #(
    parameter int WIDTH = 1
) (
    // Clocking
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             ce,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First flop feeds only the second
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sync_stage
`default_nettype wire
